/* File: tcp_regs.svh */
// Purpose: register offsets, field positions and reset values of the pulse generator
// Assumes: 8-bit I/O space addressed by the host core
// Notes:   definitions only
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// ==========================================================
// offsets
`define TCP_ADDR_CH0_CTRL  8'h20
`define TCP_ADDR_CLK_CFG   8'h21
`define TCP_ADDR_CH0_DTH   8'h22
`define TCP_ADDR_CH0_DTL   8'h23
`define TCP_ADDR_BND_H     8'h24
`define TCP_ADDR_BND_L     8'h25
`define TCP_ADDR_CH1_CTRL  8'h26
`define TCP_ADDR_CH1_DTH   8'h28
`define TCP_ADDR_CH1_DTL   8'h29
`define TCP_ADDR_CH2_CTRL  8'h2C
`define TCP_ADDR_CH2_DTH   8'h2E
`define TCP_ADDR_CH2_DTL   8'h2F

// ==========================================================
// fields
`define TCP_CTL_GATE       7
`define TCP_CTL_STAT       6
`define TCP_CTL_INV        5
`define TCP_CTL_SEL        4
`define TCP_CTL_PORT_HI    3
`define TCP_CTL_PORT_LO    1
`define TCP_CTL_COMB       0
`define TCP_CLK_EN         7
`define TCP_CLK_PRE_HI     6
`define TCP_CLK_PRE_LO     4
`define TCP_CLK_SRC        0

// ==========================================================
// port codes and reset values
`define TCP_PORT_OFF       3'h0
`define TCP_PORT_C0_PIN1   3'h1
`define TCP_PORT_C0_PIN5   3'h2
`define TCP_PORT_C0_PIN0   3'h3
`define TCP_PORT_C1_PIN6   3'h1
`define TCP_PORT_C1_PIN4   3'h3
`define TCP_PORT_C2_PIN3   3'h3
`define TCP_PORT_C2_PIN5   3'h5
`define TCP_RST_CTRL       8'h00
`define TCP_RST_CLK        8'h00
`define TCP_RST_DUTY       11'h000
`define TCP_RST_BOUND      11'h000

`endif

/* File: tcp_pkg.sv */
// Purpose: shared types of the pulse generator
// Assumes: nothing
// Notes:   constants live in tcp_regs.svh
package tcp_pkg;
    typedef logic [10:0] tcp_count_t;
    typedef logic [2:0]  tcp_port_t;
endpackage : tcp_pkg

/* File: tcp_prescale.sv */
// Purpose: power-of-two tick generator for the shared counter
// Assumes: selected source clock edge arrives as a same-domain tick
// Notes:   divides ticks by 2**sel
`timescale 1ns/1ps
`default_nettype none
module tcp_prescale (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       src_tick,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [6:0] div_q;
    logic [7:0] span;

    // ==========================================================
    // divider
    assign span = 8'(8'h01 << sel);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 7'h00;
        end else if (!run) begin
            div_q <= 7'h00;
        end else if (src_tick) begin
            if ({1'b0, div_q} >= span - 8'h01) begin
                div_q <= 7'h00;
            end else begin
                div_q <= div_q + 7'h01;
            end
        end
    end
    assign tick = run && src_tick && ({1'b0, div_q} >= span - 8'h01);
endmodule : tcp_prescale
`default_nettype wire

/* File: tcp_channel.sv */
// Purpose: one duty channel with staged low bits and compare
// Assumes: counter and run enable come from the shared stage
// Notes:   duty takes effect on the high-byte write
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.svh"
module tcp_channel (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wr_low,
    input  wire logic              wr_high,
    input  wire logic [7:0]        wdata,
    input  wire tcp_pkg::tcp_count_t count,
    input  wire logic              run,
    output logic                   raw
);
    logic [2:0]          low_q;
    tcp_pkg::tcp_count_t duty_q;

    // ==========================================================
    // duty staging
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= 3'h0;
        end else if (wr_low) begin
            low_q <= wdata[7:5];
        end
    end
    // R17 - commit on high write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_q <= `TCP_RST_DUTY;
        end else if (wr_high) begin
            duty_q <= {wdata, low_q};
        end
    end
    // R18 - high below duty
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw <= 1'b0;
        end else begin
            raw <= run && (count < duty_q);
        end
    end
endmodule : tcp_channel
`default_nettype wire

/* File: tcp_pwm.sv */
// What this block does
// R1 - control bit 7 lets the comparator gate the channel output
// R2 - control bit 6 reads the channel generator output level
// R3 - channel 0 bit 5, write-only, inverts final output
// R4 - channel 0 bit 4 combines with channel 1; bit 0 XOR or OR
// R5 - channel 0 port: off, pin one, pin five, pin zero
// R6 - channel 1 bit 5 inverts; bit 4 carries channel 2
// R7 - channel 1 port: off, pin six, pin four
// R8 - channel 2 bit 5 inverts; bit 4 halves frequency
// R9 - channel 2 port: off, pin three, pin five
// R10 - clock bit 7 write-only global enable, reset off
// R11 - clock bits 6:4 prescale by powers of two up to 128
// R12 - clock bit 0 selects system clock or fast oscillator
// R13 - duty 11 bits: high holds 10:3, low 7:5 holds 2:0
// R14 - software writes low duty before high duty
// R15 - bound high holds 10:3, low 7:6 holds 2:1, bit 0 zero
// R16 - channels 1 and 2 own duty values, same layout
// R17 - duty reaches compare only on the high write
// R18 - counter counts zero to bound then wraps; high below duty
//
// Purpose: three-channel shared-period pulse generator on the I/O bus
// Assumes: host writes/reads with one-cycle strobes; oscillator arrives as a pin
// Notes:   write-only bits read as zero
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.svh"
module tcp_pwm #(
    parameter bit FAST_DOUBLE = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic       internal_fast_oscillator,
    input  wire logic       general_comparator,
    output logic            port_pin_zero,
    output logic            port_pin_zero_oe,
    output logic            port_pin_one,
    output logic            port_pin_one_oe,
    output logic            port_pin_three,
    output logic            port_pin_three_oe,
    output logic            port_pin_four,
    output logic            port_pin_four_oe,
    output logic            port_pin_five,
    output logic            port_pin_five_oe,
    output logic            port_pin_six,
    output logic            port_pin_six_oe
);
    // ==========================================================
    // reset and pin synchronisers
    logic       rst_m_q, rst_n_q;
    logic [1:0] osc_s_q, cmp_s_q;
    logic       osc_prev_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osc_s_q    <= 2'h0;
            cmp_s_q    <= 2'h0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_s_q    <= {osc_s_q[0], internal_fast_oscillator};
            cmp_s_q    <= {cmp_s_q[0], general_comparator};
            osc_prev_q <= osc_s_q[1];
        end
    end

    // ==========================================================
    // register file
    logic [7:0]          ctl0_q, ctl1_q, ctl2_q, clk_q;
    logic [7:0]          bnd_h_q;
    logic [1:0]          bnd_l_q;
    tcp_pkg::tcp_count_t bound;
    logic                wr_ctl0, wr_ctl1, wr_ctl2, wr_clk, wr_bh, wr_bl;
    assign wr_ctl0 = io_wr && (io_addr == `TCP_ADDR_CH0_CTRL);
    assign wr_ctl1 = io_wr && (io_addr == `TCP_ADDR_CH1_CTRL);
    assign wr_ctl2 = io_wr && (io_addr == `TCP_ADDR_CH2_CTRL);
    assign wr_clk  = io_wr && (io_addr == `TCP_ADDR_CLK_CFG);
    assign wr_bh   = io_wr && (io_addr == `TCP_ADDR_BND_H);
    assign wr_bl   = io_wr && (io_addr == `TCP_ADDR_BND_L);

    // R1 - control storage per channel
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctl0_q <= `TCP_RST_CTRL;
            ctl1_q <= `TCP_RST_CTRL;
            ctl2_q <= `TCP_RST_CTRL;
        end else begin
            if (wr_ctl0) ctl0_q <= io_wdata;
            if (wr_ctl1) ctl1_q <= io_wdata;
            if (wr_ctl2) ctl2_q <= io_wdata;
        end
    end
    // R10 - enable, prescale and source
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            clk_q <= `TCP_RST_CLK;
        end else if (wr_clk) begin
            clk_q <= io_wdata;
        end
    end
    // R15 - bound halves, bit 0 held at zero
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bnd_h_q <= 8'h00;
            bnd_l_q <= 2'h0;
        end else begin
            if (wr_bh) bnd_h_q <= io_wdata;
            if (wr_bl) bnd_l_q <= io_wdata[7:6];
        end
    end
    assign bound = {bnd_h_q, bnd_l_q, 1'b0};

    // ==========================================================
    // clock stage and shared counter
    logic                run, src_tick, tick;
    tcp_pkg::tcp_count_t cnt_q;
    logic                fast_tick;
    assign run       = clk_q[`TCP_CLK_EN];
    // doubled rate counts both oscillator edges
    assign fast_tick = FAST_DOUBLE ? (osc_s_q[1] ^ osc_prev_q)
                                   : (osc_s_q[1] & ~osc_prev_q);
    // R12 - source choice
    assign src_tick  = clk_q[`TCP_CLK_SRC] ? fast_tick : 1'b1;
    // R11 - power-of-two prescaler
    tcp_prescale u_pre (
        .clk      (clk),
        .rst_n    (rst_n_q),
        .run      (run),
        .src_tick (src_tick),
        .sel      (clk_q[`TCP_CLK_PRE_HI:`TCP_CLK_PRE_LO]),
        .tick     (tick)
    );
    logic wrap;
    assign wrap = tick && (cnt_q >= bound);
    // R18 - count to bound then wrap
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= `TCP_RST_BOUND;
        end else if (!run) begin
            cnt_q <= `TCP_RST_BOUND;
        end else if (tick) begin
            cnt_q <= wrap ? 11'h000 : cnt_q + 11'h001;
        end
    end

    // ==========================================================
    // channels
    logic [2:0] raw;
    logic [7:0] addr_lo [3];
    logic [7:0] addr_hi [3];
    assign addr_lo[0] = `TCP_ADDR_CH0_DTL;
    assign addr_hi[0] = `TCP_ADDR_CH0_DTH;
    assign addr_lo[1] = `TCP_ADDR_CH1_DTL;
    assign addr_hi[1] = `TCP_ADDR_CH1_DTH;
    assign addr_lo[2] = `TCP_ADDR_CH2_DTL;
    assign addr_hi[2] = `TCP_ADDR_CH2_DTH;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            // R13 - low then high duty bytes
            // R16 - each channel own duty
            tcp_channel u_ch (
                .clk     (clk),
                .rst_n   (rst_n_q),
                .wr_low  (io_wr && (io_addr == addr_lo[g])),
                .wr_high (io_wr && (io_addr == addr_hi[g])),
                .wdata   (io_wdata),
                .count   (cnt_q),
                .run     (run),
                .raw     (raw[g])
            );
        end
    endgenerate

    // ==========================================================
    // output shaping
    logic half_q;
    // R8 - halve by toggling on each rise of channel 2
    logic raw2_prev_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            raw2_prev_q <= 1'b0;
            half_q      <= 1'b0;
        end else begin
            raw2_prev_q <= raw[2];
            if (!run) half_q <= 1'b0;
            else if (raw[2] && !raw2_prev_q) half_q <= ~half_q;
        end
    end
    logic w2, w1, w0, comb, o0, o1, o2;
    logic cmp;
    assign cmp = cmp_s_q[1];
    assign w2  = ctl2_q[`TCP_CTL_SEL] ? half_q : raw[2];
    // R6 - channel 1 path source
    assign w1  = ctl1_q[`TCP_CTL_SEL] ? w2 : raw[1];
    // R4 - combine channel 0 with 1
    assign comb = ctl0_q[`TCP_CTL_COMB] ? (raw[0] | raw[1]) : (raw[0] ^ raw[1]);
    assign w0  = ctl0_q[`TCP_CTL_SEL] ? comb : raw[0];
    // R1 - comparator gating; R3 R6 R8 - polarity
    assign o0  = (w0 & ~(ctl0_q[`TCP_CTL_GATE] & ~cmp)) ^ ctl0_q[`TCP_CTL_INV];
    assign o1  = (w1 & ~(ctl1_q[`TCP_CTL_GATE] & ~cmp)) ^ ctl1_q[`TCP_CTL_INV];
    assign o2  = (w2 & ~(ctl2_q[`TCP_CTL_GATE] & ~cmp)) ^ ctl2_q[`TCP_CTL_INV];

    // ==========================================================
    // pin routing; pin five shared, channel 0 wins
    tcp_pkg::tcp_port_t p0, p1, p2;
    assign p0 = ctl0_q[`TCP_CTL_PORT_HI:`TCP_CTL_PORT_LO];
    assign p1 = ctl1_q[`TCP_CTL_PORT_HI:`TCP_CTL_PORT_LO];
    assign p2 = ctl2_q[`TCP_CTL_PORT_HI:`TCP_CTL_PORT_LO];
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            port_pin_zero_oe  <= 1'b0;
            port_pin_one_oe   <= 1'b0;
            port_pin_three_oe <= 1'b0;
            port_pin_four_oe  <= 1'b0;
            port_pin_five_oe  <= 1'b0;
            port_pin_six_oe   <= 1'b0;
            port_pin_zero     <= 1'b0;
            port_pin_one      <= 1'b0;
            port_pin_three    <= 1'b0;
            port_pin_four     <= 1'b0;
            port_pin_five     <= 1'b0;
            port_pin_six      <= 1'b0;
        end else begin
            // R5 - channel 0 pins
            port_pin_one_oe   <= (p0 == `TCP_PORT_C0_PIN1);
            port_pin_zero_oe  <= (p0 == `TCP_PORT_C0_PIN0);
            // R7 - channel 1 pins
            port_pin_six_oe   <= (p1 == `TCP_PORT_C1_PIN6);
            port_pin_four_oe  <= (p1 == `TCP_PORT_C1_PIN4);
            // R9 - channel 2 pins
            port_pin_three_oe <= (p2 == `TCP_PORT_C2_PIN3);
            port_pin_five_oe  <= (p0 == `TCP_PORT_C0_PIN5) || (p2 == `TCP_PORT_C2_PIN5);
            port_pin_zero     <= o0;
            port_pin_one      <= o0;
            port_pin_six      <= o1;
            port_pin_four     <= o1;
            port_pin_three    <= o2;
            port_pin_five     <= (p0 == `TCP_PORT_C0_PIN5) ? o0 : o2;
        end
    end

    // ==========================================================
    // read path; R14 ordering is the host's duty, write-only bits read zero
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            // R2 - live generator level
            if (io_addr == `TCP_ADDR_CH0_CTRL) begin
                io_rdata <= {ctl0_q[7], raw[0], 1'b0, ctl0_q[4:0]};
            end else if (io_addr == `TCP_ADDR_CH1_CTRL) begin
                io_rdata <= {ctl1_q[7], raw[1], ctl1_q[5:0]};
            end else if (io_addr == `TCP_ADDR_CH2_CTRL) begin
                io_rdata <= {ctl2_q[7], raw[2], ctl2_q[5:0]};
            end else begin
                io_rdata <= 8'h00;
            end
        end
    end

    // ==========================================================
    // checks
    chk_enable_stops: assert property (@(posedge clk) disable iff (!rst_n_q) // R10
        !run |=> cnt_q == 11'h000)
        else $error("counter moved while disabled");
    chk_count_bound: assert property (@(posedge clk) disable iff (!rst_n_q) // R18
        (run && tick && cnt_q >= bound) |=> cnt_q == 11'h000)
        else $error("counter did not wrap at bound");
    chk_bound_bit0: assert property (@(posedge clk) disable iff (!rst_n_q) // R15
        bound[0] == 1'b0)
        else $error("bound bit zero set");
    chk_off_pins: assert property (@(posedge clk) disable iff (!rst_n_q) // R5
        (p0 == `TCP_PORT_OFF && p2 == `TCP_PORT_OFF) |=> !port_pin_five_oe)
        else $error("pin five driven while off");
    chk_pin_six: assert property (@(posedge clk) disable iff (!rst_n_q) // R7
        (p1 == `TCP_PORT_C1_PIN6) |=> port_pin_six_oe && port_pin_six == $past(o1))
        else $error("pin six wrong");
    chk_pin_three: assert property (@(posedge clk) disable iff (!rst_n_q) // R9
        (p2 == `TCP_PORT_C2_PIN3) |=> port_pin_three == $past(o2))
        else $error("pin three wrong");
    chk_status_read: assert property (@(posedge clk) disable iff (!rst_n_q) // R2
        (io_rd && io_addr == `TCP_ADDR_CH1_CTRL) |=> io_rdata[6] == $past(raw[1]))
        else $error("status bit wrong");
    chk_polarity_inv: assert property (@(posedge clk) disable iff (!rst_n_q) // R3
        (ctl0_q[4] == 1'b0 && ctl0_q[7] == 1'b0) |-> o0 == (raw[0] ^ ctl0_q[5]))
        else $error("channel 0 polarity wrong");
    chk_comb_or: assert property (@(posedge clk) disable iff (!rst_n_q) // R4
        (ctl0_q[4] && ctl0_q[0] && !ctl0_q[7]) |-> (o0 ^ ctl0_q[5]) == (raw[0] | raw[1]))
        else $error("combine wrong");
    chk_gate_cmp: assert property (@(posedge clk) disable iff (!rst_n_q) // R1
        (ctl1_q[7] && !cmp && !ctl1_q[5]) |-> !o1)
        else $error("gating failed");

    chk_comb_xor: assert property (@(posedge clk) disable iff (!rst_n_q) // R4
        (ctl0_q[4] && !ctl0_q[0] && !ctl0_q[7]) |-> (o0 ^ ctl0_q[5]) == (raw[0] ^ raw[1]))
        else $error("xor combine wrong");

    chk_pin_zero: assert property (@(posedge clk) disable iff (!rst_n_q) // R5
        (p0 == `TCP_PORT_C0_PIN0) |=> port_pin_zero_oe && port_pin_zero == $past(o0))
        else $error("pin zero wrong");

    chk_pin_one: assert property (@(posedge clk) disable iff (!rst_n_q) // R5
        (p0 == `TCP_PORT_C0_PIN1) |=> port_pin_one_oe && port_pin_one == $past(o0))
        else $error("pin one wrong");

    chk_pin_four: assert property (@(posedge clk) disable iff (!rst_n_q) // R7
        (p1 == `TCP_PORT_C1_PIN4) |=> port_pin_four_oe && port_pin_four == $past(o1))
        else $error("pin four wrong");

    // channel 2 drives pin five when channel 0 does not ask for it
    chk_pin_five: assert property (@(posedge clk) disable iff (!rst_n_q) // R9
        (p2 == `TCP_PORT_C2_PIN5 && p0 != `TCP_PORT_C0_PIN5)
        |=> port_pin_five_oe && port_pin_five == $past(o2))
        else $error("pin five wrong");

    chk_src_ch2: assert property (@(posedge clk) disable iff (!rst_n_q) // R6
        (ctl1_q[4] && !ctl1_q[7]) |-> (o1 ^ ctl1_q[5]) == w2)
        else $error("channel 1 source wrong");

    chk_half_toggle: assert property (@(posedge clk) disable iff (!rst_n_q) // R8
        (run && raw[2] && !raw2_prev_q) |=> half_q != $past(half_q))
        else $error("halver did not toggle");

    chk_raw_idle: assert property (@(posedge clk) disable iff (!rst_n_q) // R10
        !run |=> raw == 3'h0)
        else $error("channel active while disabled");

    // ==========================================================
    // coverage
    cov_run: cover property (@(posedge clk) disable iff (!rst_n_q) run && wrap);
    cov_raw0: cover property (@(posedge clk) disable iff (!rst_n_q) raw[0] ##1 !raw[0]);
    cov_half: cover property (@(posedge clk) disable iff (!rst_n_q) $rose(half_q));
    cov_gate: cover property (@(posedge clk) disable iff (!rst_n_q) ctl1_q[7] && !cmp && raw[1]);
    cov_fast: cover property (@(posedge clk) disable iff (!rst_n_q) clk_q[0] && tick);
endmodule : tcp_pwm
`default_nettype wire

/* File: tcp_host_model.sv */
// Purpose: host core model issuing I/O writes and reads to the pulse generator
// Assumes: one-cycle strobes launched at falling edges, taken at the next rising edge
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.svh"
module tcp_host_model (
    input  wire logic       clk,
    output logic      [7:0] io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    localparam logic [7:0] DTL [3] = '{`TCP_ADDR_CH0_DTL, `TCP_ADDR_CH1_DTL, `TCP_ADDR_CH2_DTL};
    localparam logic [7:0] DTH [3] = '{`TCP_ADDR_CH0_DTH, `TCP_ADDR_CH1_DTH, `TCP_ADDR_CH2_DTH};

    initial begin
        io_addr  = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // ==========================================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clk);
        io_wr    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge clk);
        io_rd   = 1'b0;
        io_addr = ~a;
        @(negedge clk);
        d = io_rdata;
    endtask : rd

    // ==========================================================
    // duty update
    // low byte first, then high
    task automatic set_duty(input int ch, input logic [10:0] duty);
        wr(DTL[ch], {duty[2:0], 5'h00});
        wr(DTH[ch], duty[10:3]);
    endtask : set_duty
endmodule : tcp_host_model
`default_nettype wire

/* File: tcp_pwm_test.sv */
// Purpose: self-checking bench of the three-channel pulse generator
// Assumes: host model drives the bus; bound 8 gives a nine-tick period
// Notes:   high-time windows span whole periods, so phase does not matter
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.svh"
module tcp_pwm_test;
    logic       clk       = 1'b0;
    logic       rstn      = 1'b0;
    logic       osc       = 1'b0;
    logic       cmp       = 1'b1;
    wire  [7:0] io_addr;
    wire  [7:0] io_wdata;
    wire  [7:0] io_rdata;
    wire        io_wr;
    wire        io_rd;
    wire  [5:0] pin;
    wire  [5:0] oe;
    logic [7:0] rv;
    int         error_cnt = 0;
    int         tests_run = 0;

    localparam logic [7:0] CTRL [3] = '{`TCP_ADDR_CH0_CTRL, `TCP_ADDR_CH1_CTRL, `TCP_ADDR_CH2_CTRL};
    // pin order: zero, one, three, four, five, six
    localparam logic [5:0] OE_TAB [3][8] = '{
        '{6'h00, 6'h02, 6'h10, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00},
        '{6'h00, 6'h20, 6'h00, 6'h08, 6'h00, 6'h00, 6'h00, 6'h00},
        '{6'h00, 6'h00, 6'h00, 6'h04, 6'h00, 6'h10, 6'h00, 6'h00}};

    always #10 clk = ~clk;
    // oscillator runs free, five system clocks per cycle, offset from both edges
    initial begin
        #3;
        forever #50 osc = ~osc;
    end

    tcp_host_model i_tcp_host_model (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));

    tcp_pwm i_tcp_pwm (.clk(clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .internal_fast_oscillator(osc), .general_comparator(cmp),
        .port_pin_zero(pin[0]), .port_pin_zero_oe(oe[0]),
        .port_pin_one(pin[1]), .port_pin_one_oe(oe[1]),
        .port_pin_three(pin[2]), .port_pin_three_oe(oe[2]),
        .port_pin_four(pin[3]), .port_pin_four_oe(oe[3]),
        .port_pin_five(pin[4]), .port_pin_five_oe(oe[4]),
        .port_pin_six(pin[5]), .port_pin_six_oe(oe[5]));

    // ==========================================================
    // helpers
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : check8

    // settle, then count high cycles of one pin over n cycles
    task automatic measure(input int idx, input int n, input int exp);
        int hi;
        hi = 0;
        repeat (n + 4) @(negedge clk);
        repeat (n) begin
            @(negedge clk);
            if (pin[idx] === 1'b1) hi++;
        end
        tests_run++;
        if (hi != exp) begin
            error_cnt++;
            $display("Error at %0t: pin %0d high %0d, expected %0d", $time, idx, hi, exp);
        end
    endtask : measure

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_tcp_host_model.wr(a, d);
    endtask : wr

    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [7:0] adr [6];
        adr = '{8'h20, 8'h26, 8'h2C, 8'h21, 8'h22, 8'h30};
        check8({2'b00, oe}, 8'h00);
        foreach (adr[i]) begin
            i_tcp_host_model.rd(adr[i], rv);
            check8(rv, 8'h00);
        end
    endtask : t_reset

    task automatic t_routing;
        for (int ch = 0; ch < 3; ch++) begin
            for (int code = 0; code < 8; code++) begin
                wr(CTRL[ch], 8'(code << 1));
                repeat (4) @(negedge clk);
                check8({2'b00, oe}, {2'b00, OE_TAB[ch][code]});
            end
            wr(CTRL[ch], 8'h00);
        end
    endtask : t_routing

    task automatic t_duty;
        wr(`TCP_ADDR_BND_L, 8'h00);
        wr(`TCP_ADDR_BND_H, 8'h01);
        wr(`TCP_ADDR_CLK_CFG, 8'h80);
        wr(CTRL[0], 8'h02);
        i_tcp_host_model.set_duty(0, 11'h003);
        measure(1, 9, 3);
        wr(`TCP_ADDR_CH0_DTL, 8'hC0);
        measure(1, 9, 3);
        wr(`TCP_ADDR_CH0_DTH, 8'h00);
        measure(1, 9, 6);
        // bound bit 0 stays clear: bound 14, period 15
        wr(`TCP_ADDR_BND_L, 8'hFF);
        measure(1, 15, 6);
        wr(`TCP_ADDR_BND_L, 8'h00);
        i_tcp_host_model.set_duty(0, 11'h003);
    endtask : t_duty

    task automatic t_prescale;
        for (int sel = 0; sel < 8; sel++) begin
            wr(`TCP_ADDR_CLK_CFG, 8'(8'h80 | (sel << 4)));
            measure(1, 9 << sel, 3 << sel);
        end
        wr(`TCP_ADDR_CLK_CFG, 8'h81);
        measure(1, 45, 15);
        wr(`TCP_ADDR_CLK_CFG, 8'h00);
        measure(1, 9, 0);
        wr(`TCP_ADDR_CLK_CFG, 8'h80);
    endtask : t_prescale

    task automatic t_combine;
        i_tcp_host_model.set_duty(1, 11'h005);
        i_tcp_host_model.set_duty(2, 11'h007);
        wr(CTRL[0], 8'h12);
        measure(1, 9, 2);
        wr(CTRL[0], 8'h13);
        measure(1, 9, 5);
        wr(CTRL[0], 8'h33);
        measure(1, 9, 4);
        wr(CTRL[1], 8'h02);
        measure(5, 9, 5);
        wr(CTRL[1], 8'h22);
        measure(5, 9, 4);
        wr(CTRL[1], 8'h12);
        measure(5, 9, 7);
        wr(CTRL[2], 8'h06);
        measure(2, 9, 7);
        wr(CTRL[2], 8'h16);
        measure(2, 18, 9);
        wr(CTRL[2], 8'h26);
        measure(2, 9, 2);
        wr(CTRL[0], 8'h06);
        measure(0, 9, 3);
        wr(CTRL[1], 8'h06);
        measure(3, 9, 5);
        wr(CTRL[2], 8'h0A);
        measure(4, 9, 7);
    endtask : t_combine

    task automatic t_gate;
        wr(CTRL[0], 8'h82);
        wr(CTRL[1], 8'h82);
        @(negedge clk);
        cmp = 1'b0;
        measure(1, 9, 0);
        measure(5, 9, 0);
        @(negedge clk);
        cmp = 1'b1;
        measure(1, 9, 3);
        measure(5, 9, 5);
    endtask : t_gate

    task automatic t_status;
        wr(CTRL[0], 8'hB3);
        i_tcp_host_model.set_duty(0, 11'h7FF);
        i_tcp_host_model.set_duty(1, 11'h7FF);
        i_tcp_host_model.set_duty(2, 11'h7FF);
        wr(CTRL[1], 8'h22);
        wr(CTRL[2], 8'h2A);
        repeat (6) @(negedge clk);
        i_tcp_host_model.rd(CTRL[0], rv);
        check8(rv, 8'hD3);
        i_tcp_host_model.rd(CTRL[1], rv);
        check8(rv, 8'h62);
        i_tcp_host_model.rd(CTRL[2], rv);
        check8(rv, 8'h6A);
        i_tcp_host_model.set_duty(0, 11'h000);
        repeat (6) @(negedge clk);
        i_tcp_host_model.rd(CTRL[0], rv);
        check8(rv, 8'h93);
    endtask : t_status

    // ==========================================================
    // verdict
    task final_report;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // whole sequence takes about 6000 cycles; this allows eight times that
    initial begin
        #1000000;
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_routing();
        t_duty();
        t_prescale();
        t_combine();
        t_gate();
        t_status();
        final_report();
    end
endmodule : tcp_pwm_test
`default_nettype wire
